// >>> ufb_top.sv
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module ufb_top
    import ufb_pkg::*;
#(
    parameter int SUSPEND_REQUEST_FLAG_IDLE_CYCLES = SUSPEND_REQUEST_FLAG_IDLE_CYC
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,          // low freezes all state (halt)
    // register port
    input  wire logic [3:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    // serial_interface_engine events
    input  wire ufb_pkt_type i_pkt,
    input  wire logic        i_setup_ovr,
    input  wire logic        i_bus_err,
    input  wire logic        i_bus_reset,
    input  wire logic        i_sof,
    input  wire logic        i_bus_idle,    // line state, asynchronous
    input  wire logic        i_suspended,
    // transfer_coprocessor block release
    input  wire logic        i_blk_release, // one-cycle pulse
    input  wire logic        i_blk_sel,
    // processor
    input  wire logic        i_global_mask, // high blocks all requests
    // outputs
    output logic      [9:0]  o_ep2_addr,    // ep2 physical buffer offset
    output logic             o_ep2_nak,     // ep2 must answer nak
    output logic      [1:0]  o_block_status_pair,
    output logic             o_current_block_index,
    output logic             o_irq_main,
    output logic             o_irq_wake
);
    // ==========================================================
    // registers
    logic [1:0]  mode_ff;
    logic [7:0]  int_flag_ff;
    logic [7:0]  int_en_ff;
    logic [1:0]  ep2_valid_ff;         // bit0 rx, bit1 tx
    logic [6:0]  ep2_count_ff;
    logic [2:0]  pkt_cnt_ff;
    logic        blk_ff;
    logic [1:0]  stat_ff;
    ufb_mgr_type state_ff;
    logic [7:0]  rdata_ff;
    logic [2:0]  idle_sync_ff;
    logic [31:0] idle_cnt_ff;
    logic        suspend_request_flag_prev_ff;
    logic        idle_seen_ff;
    logic        idle_lvl_ff;          // idle level once two stages agree

    // ==========================================================
    // decode
    wire wr_ctl     = i_wr && (i_addr == REG_CONTROL);
    wire wr_buf     = i_wr && (i_addr == REG_BUF_CTRL);
    wire wr_istat   = i_wr && (i_addr == REG_INT_STATUS);
    wire wr_ien     = i_wr && (i_addr == REG_INT_ENABLE);
    wire wr_ep2     = i_wr && (i_addr == REG_EP2_STATUS);
    wire reinit     = wr_buf && i_wdata[BUF_REINIT_BIT];
    wire ep2_pkt    = i_pkt.done && (i_pkt.ep == 2'h2);
    wire streaming  = (mode_ff == MODE_UPLOAD) || (mode_ff == MODE_DOWNLOAD);
    wire short_pkt  = ep2_pkt && streaming && (i_pkt.count < EP2_MAX_PACKET);
    wire blk_last   = (pkt_cnt_ff == PKTS_PER_BLOCK);
    wire stream_pkt = ep2_pkt && streaming && !short_pkt && (state_ff == MGR_STREAM);
    wire blk_done   = stream_pkt && blk_last;
    wire other_rdy  = stat_ff[~blk_ff] == (mode_ff == MODE_UPLOAD);
    wire cur_rdy    = stat_ff[blk_ff]  == (mode_ff == MODE_UPLOAD);
    wire rel_hit    = i_blk_release;
    // status: upload full=1 ready; download empty=0 ready
    wire [1:0] rel_val = {2{mode_ff == MODE_UPLOAD}};

    // ==========================================================
    // pin input synchroniser and idle timer
    wire idle_stable = idle_lvl_ff;   // second and third stage agreed on it
    wire suspend_request_flag_evt    = idle_stable && (idle_cnt_ff == SUSPEND_REQUEST_FLAG_IDLE_CYCLES - 1) && !idle_seen_ff;
    wire suspend_end_flag_evt   = suspend_request_flag_prev_ff && !i_suspended; // bus activity ends suspend

    // ==========================================================
    // event vector; set wins over software clear
    logic [7:0] events;
    always_comb begin
        events           = RESET_BYTE;
        events[IRQ_CTR]   = i_pkt.done;
        events[IRQ_SETUP_OVERRUN_FLAG]  = i_setup_ovr;
        events[IRQ_ERR]   = i_bus_err;          // crc/stuff/framing errors
        events[IRQ_SUSPEND_REQUEST_FLAG]  = suspend_request_flag_evt;
        events[IRQ_SUSPEND_END_FLAG] = suspend_end_flag_evt;
        events[IRQ_RESET] = i_bus_reset;
        events[IRQ_SOF]   = i_sof;
    end
    wire [7:0] nxt_int_flag = ((wr_istat ? (int_flag_ff & i_wdata) : int_flag_ff) | events) & IRQ_VALID_MASK;
    wire [7:0] req = int_flag_ff & int_en_ff & {8{!i_global_mask}};
    // separate wake vector for suspend end only
    assign o_irq_wake = req[IRQ_SUSPEND_END_FLAG];
    assign o_irq_main = |(req & ~(8'h01 << IRQ_SUSPEND_END_FLAG));

    // ==========================================================
    // outputs
    assign o_ep2_addr            = {blk_ff, 9'h000} + {pkt_cnt_ff, 6'h00};
    assign o_ep2_nak             = streaming ? ((state_ff != MGR_STREAM) || !cur_rdy) : 1'b0;
    assign o_block_status_pair   = stat_ff;
    assign o_current_block_index = blk_ff;
    assign o_rdata               = rdata_ff;

    // ==========================================================
    // read mux, answered next cycle
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = RESET_BYTE;
        case (i_addr)
            REG_CONTROL:    rd_mux = {2'h0, mode_ff, 4'h0};
            REG_BUF_CTRL:   rd_mux = {4'h0, blk_ff, stat_ff, 1'b0};
            REG_INT_STATUS: rd_mux = int_flag_ff;
            REG_INT_ENABLE: rd_mux = int_en_ff;
            REG_EP2_STATUS: rd_mux = {6'h00, ep2_valid_ff};
            REG_EP2_COUNT:  rd_mux = {1'b0, ep2_count_ff};
            REG_EP_ADDR:    rd_mux = o_ep2_addr[7:0];
            REG_EP_ADDR_HI: rd_mux = {6'h00, o_ep2_addr[9:8]};
            default:        rd_mux = RESET_BYTE;
        endcase
    end

    // ==========================================================
    // manager next state; independent of the processor
    ufb_mgr_type nxt_state;
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            MGR_IDLE:   nxt_state = streaming ? (cur_rdy ? MGR_STREAM : MGR_WAIT) : MGR_IDLE;
            MGR_STREAM: begin
                if (short_pkt)
                    nxt_state = MGR_SHORT;
                else if (!streaming)
                    nxt_state = MGR_IDLE;
                else if (blk_done)
                    nxt_state = other_rdy ? MGR_STREAM : MGR_WAIT;
                else if (!cur_rdy)
                    nxt_state = MGR_WAIT;                          // mode flip onto an unready block
            end
            MGR_WAIT:   nxt_state = !streaming ? MGR_IDLE : (cur_rdy ? MGR_STREAM : MGR_WAIT);
            MGR_SHORT:  nxt_state = MGR_IDLE;
            default:    nxt_state = MGR_IDLE;
        endcase
        if (reinit)
            nxt_state = MGR_IDLE;
    end

    // block status: usb consumption flips current, release restores
    logic [1:0] nxt_stat;
    always_comb begin
        nxt_stat = stat_ff;
        if (blk_done)
            nxt_stat[blk_ff] = ~rel_val[0];  // upload sent: not full; download filled
        if (rel_hit)
            nxt_stat[i_blk_sel] = rel_val[0];
        if (reinit)
            nxt_stat = 2'h0;
    end

    // ==========================================================
    // state
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            mode_ff      <= MODE_NORMAL;
            int_flag_ff  <= RESET_BYTE;
            int_en_ff    <= RESET_BYTE;
            ep2_valid_ff <= 2'h0;
            ep2_count_ff <= 7'h00;
            rdata_ff     <= RESET_BYTE;
            idle_sync_ff <= 3'h0;
            idle_lvl_ff  <= 1'b0;
            suspend_request_flag_prev_ff <= 1'b0;
            state_ff     <= MGR_IDLE;
        end else if (i_ce) begin                                   // frozen in halt
            if (short_pkt)
                mode_ff <= MODE_NORMAL;
            else if (wr_ctl)
                mode_ff <= i_wdata[MODE_LSB +: 2];
            int_flag_ff  <= nxt_int_flag;
            if (wr_ien)
                int_en_ff <= i_wdata & IRQ_VALID_MASK;
            rdata_ff     <= i_rd ? rd_mux : RESET_BYTE;
            idle_sync_ff <= {idle_sync_ff[1:0], i_bus_idle};
            if (idle_sync_ff[2] == idle_sync_ff[1])
                idle_lvl_ff <= idle_sync_ff[2];                    // a lone glitch never counts
            suspend_request_flag_prev_ff <= i_suspended;
            state_ff     <= nxt_state;
            if (ep2_pkt)
                ep2_count_ff <= i_pkt.count;
            // normal mode forces nak after correct transfer, forced clear wins over software write
            if (ep2_pkt && !streaming)
                ep2_valid_ff[i_pkt.is_in] <= 1'b0;
            else if (wr_ep2)
                ep2_valid_ff <= i_wdata[1:0];
        end
    end

    // manager counters
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pkt_cnt_ff <= 3'h0;
            blk_ff     <= 1'b0;
            stat_ff    <= 2'h0;
        end else if (i_ce) begin
            stat_ff <= nxt_stat;
            if (reinit) begin
                pkt_cnt_ff <= 3'h0;
                blk_ff     <= 1'b0;
            end else if (stream_pkt) begin
                pkt_cnt_ff <= pkt_cnt_ff + 3'h1;                   // wraps at block end
                if (blk_last)
                    blk_ff <= ~blk_ff;
            end
        end
    end

    // idle timer; saturates so the flag sets once per idle period
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            idle_cnt_ff  <= 32'h0;
            idle_seen_ff <= 1'b0;
        end else if (i_ce) begin
            if (!idle_stable || i_bus_reset) begin
                idle_cnt_ff  <= 32'h0;
                idle_seen_ff <= 1'b0;
            end else if (suspend_request_flag_evt)
                idle_seen_ff <= 1'b1;
            else if (!idle_seen_ff)
                idle_cnt_ff <= idle_cnt_ff + 32'h1;
        end
    end
endmodule : ufb_top

// >>> ufb_pkg.sv
// Contract
// - engine generates and checks crc, does nrzi coding and bit stuffing on the bus.
// - five endpoints: control ep0, ep1 and ep2 each one in and one out.
// - ep0 and ep1 own two 16-byte buffers, ep2 owns two 64-byte buffers.
// - ep2 mode field: 00 normal, 01 upload, 10 download; selects ep2 buffer area.
// - token to valid endpoint moves transaction data to or from that endpoint buffer.
// - normal mode raises an interrupt when each endpoint transaction finishes.
// - normal mode limits ep2 to 64 bytes; 512 bytes need service per packet.
// - normal mode forces ep2 direction status to nak after correct transfer; software revalidates.
// - data buffer is double: coprocessor uses one 512-byte block, usb the other.
// - upload/download advances ep2 address by 64 per packet until block full.
// - after 512 bytes the manager switches to the other block if available.
// - if next block unavailable, ep2 answers not available until coprocessor releases one.
// - manager answers nak on ep2 while current block is not ready.
// - manager is an independent state machine running beside the processor.
// - writing 1 to reinit control restarts the manager so both sides resynchronise.
// - dedicated buffer status flags are readable by the coprocessor.
// - short packet in upload or download reverts ep2 to normal mode.
// - short packet stored in a block; last addressed block index kept for software.
// - in wait the logic runs and enabled events wake the device.
// - in halt logic is frozen; bus activity in suspend raises suspend end event. The code latches it only while i_ce is high, never during halt.
// - seven events request interrupts only when enabled and global mask clear.
// - suspend end uses its own wake vector; others share a non-waking vector.
// - block status 0 not full/empty, 1 full to send or holding unconsumed data.
// - reinit write also zeroes block index, both status bits and packet counter.
// - suspend request flag sets after bus idle longer than 3 ms.
package ufb_pkg;
    // ==========================================================
    // register map
    localparam logic [3:0] REG_CONTROL     = 4'h0; // usb_control_reg: mode
    localparam logic [3:0] REG_BUF_CTRL    = 4'h1; // buffer_control_status
    localparam logic [3:0] REG_INT_STATUS  = 4'h2;
    localparam logic [3:0] REG_INT_ENABLE  = 4'h3;
    localparam logic [3:0] REG_EP2_STATUS  = 4'h4; // bit0 rx valid, bit1 tx valid
    localparam logic [3:0] REG_EP2_COUNT   = 4'h5; // last packet byte count
    localparam logic [3:0] REG_EP_ADDR     = 4'h6; // ep2 physical address low
    localparam logic [3:0] REG_EP_ADDR_HI  = 4'h7;
    // field positions
    localparam int BUF_REINIT_BIT = 0;
    localparam int MODE_LSB       = 4;
    // modes
    localparam logic [1:0] MODE_NORMAL   = 2'h0;
    localparam logic [1:0] MODE_UPLOAD   = 2'h1;
    localparam logic [1:0] MODE_DOWNLOAD = 2'h2;
    // interrupt bit positions
    localparam int IRQ_CTR   = 7;
    localparam int IRQ_SETUP_OVERRUN_FLAG  = 5;
    localparam int IRQ_ERR   = 4;
    localparam int IRQ_SUSPEND_REQUEST_FLAG  = 3;
    localparam int IRQ_SUSPEND_END_FLAG = 2;
    localparam int IRQ_RESET = 1;
    localparam int IRQ_SOF   = 0;
    localparam logic [7:0] IRQ_VALID_MASK = 8'hBF;
    // sizes
    localparam logic [6:0] EP2_MAX_PACKET = 7'h40;
    localparam logic [9:0] EP2_STEP       = 10'h040;
    localparam logic [2:0] PKTS_PER_BLOCK = 3'h7; // last packet index of a block
    localparam logic [7:0] RESET_BYTE     = 8'h00;
    // timing
    localparam int CLK_HZ          = 10_000_000;
    localparam int SUSPEND_REQUEST_FLAG_IDLE_US    = 3000;
    localparam int SUSPEND_REQUEST_FLAG_IDLE_CYC   = (CLK_HZ / 1_000_000) * SUSPEND_REQUEST_FLAG_IDLE_US + 1;
    // manager states
    typedef enum logic [3:0] {
        MGR_IDLE   = 4'h1,
        MGR_STREAM = 4'h2,
        MGR_WAIT   = 4'h4,
        MGR_SHORT  = 4'h8
    } ufb_mgr_type;
    // packet completion report from serial_interface_engine
    typedef struct packed {
        logic       done;   // one-cycle pulse
        logic       is_in;  // 1 in (tx), 0 out (rx)
        logic [1:0] ep;
        logic [6:0] count;
    } ufb_pkt_type;
endpackage : ufb_pkg

// >>> ufb_checker_assertions.sv
`timescale 1ns/1ps
module ufb_checker
    import ufb_pkg::*;
#(
    parameter int SUSPEND_REQUEST_FLAG_IDLE_CYCLES = SUSPEND_REQUEST_FLAG_IDLE_CYC
) (
    // watched ports
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_ce,
    input wire logic [3:0]  i_addr,
    input wire logic [7:0]  i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire ufb_pkt_type i_pkt,
    input wire logic        i_suspended,
    input wire logic        i_blk_release,
    input wire logic        i_global_mask,
    input wire logic [7:0]  o_rdata,
    input wire logic [9:0]  o_ep2_addr,
    input wire logic        o_ep2_nak,
    input wire logic [1:0]  o_block_status_pair,
    input wire logic        o_current_block_index,
    input wire logic        o_irq_main,
    input wire logic        o_irq_wake
);
    // ==========================================================
    // properties
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    property p_mask;
        i_global_mask && $past(i_global_mask) |-> !o_irq_main && !o_irq_wake;
    endproperty
    a_mask: assert property (p_mask) else $error("irq while masked");
    property p_halt;
        !i_ce |=> $stable(o_block_status_pair) && $stable(o_current_block_index);
    endproperty
    a_halt: assert property (p_halt) else $error("state moved in halt");
    property p_rst;
        $rose(i_rst_n) |-> o_block_status_pair == 2'h0 && !o_current_block_index && o_ep2_addr == 10'h000;
    endproperty
    a_rst: assert property (p_rst) else $error("bad state after reset");
    property p_reinit;
        i_wr && i_ce && i_addr == REG_BUF_CTRL && i_wdata[BUF_REINIT_BIT]
            |=> o_block_status_pair == 2'h0 && !o_current_block_index;
    endproperty
    a_reinit: assert property (p_reinit) else $error("reinit left state");
    property p_addr;
        o_ep2_addr[5:0] == 6'h00 && o_ep2_addr[9] == o_current_block_index;
    endproperty
    a_addr: assert property (p_addr) else $error("ep2 address off grid");
    property p_toggle;
        $changed(o_current_block_index) |-> $past(i_pkt.done) || $past(i_wr) || !$past(i_rst_n);
    endproperty
    a_toggle: assert property (p_toggle) else $error("block moved unprompted");
    property p_nak;
        $fell(o_ep2_nak) |-> $past(i_blk_release) || $past(i_blk_release, 2) || $past(i_wr) || $past(i_wr, 2)
            || $past(i_pkt.done) || !$past(i_rst_n);
    endproperty
    a_nak: assert property (p_nak) else $error("nak dropped unprompted");
    property p_wake;
        $rose(o_irq_wake) |-> !i_suspended;
    endproperty
    a_wake: assert property (p_wake) else $error("wake while suspended");
    property p_bufrd;
        i_rd && i_ce && i_addr == REG_BUF_CTRL
            |=> o_rdata[7:1] == {4'h0, $past(o_current_block_index), $past(o_block_status_pair)};
    endproperty
    a_bufrd: assert property (p_bufrd) else $error("buffer status read wrong");
    // main scenarios reached
    c_nak: cover property (o_ep2_nak ##1 !o_ep2_nak);
    c_irq: cover property (o_irq_main);
    c_wake: cover property (o_irq_wake);
endmodule : ufb_checker

bind ufb_top ufb_checker #(.SUSPEND_REQUEST_FLAG_IDLE_CYCLES(SUSPEND_REQUEST_FLAG_IDLE_CYCLES)) u_ufb_checker (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_pkt(i_pkt), .i_suspended(i_suspended),
    .i_blk_release(i_blk_release), .i_global_mask(i_global_mask), .o_rdata(o_rdata),
    .o_ep2_addr(o_ep2_addr), .o_ep2_nak(o_ep2_nak), .o_block_status_pair(o_block_status_pair),
    .o_current_block_index(o_current_block_index), .o_irq_main(o_irq_main), .o_irq_wake(o_irq_wake)
);

// >>> ufb_eng_model.sv
`timescale 1ns/1ps
module ufb_eng_model
    import ufb_pkg::*;
(
    input  wire logic   i_clk,
    output ufb_pkt_type o_pkt,
    output logic        o_bus_idle,
    output logic        o_suspended
);
    // ==========================================================
    // line and transaction reports
    initial begin
        o_pkt = '0;
        o_bus_idle = 1'b0;
        o_suspended = 1'b0;
    end
    // fields are scrambled once done drops so stale values never pass
    task automatic send(input logic is_in, input logic [1:0] ep, input logic [6:0] cnt);
        @(posedge i_clk);
        o_pkt <= '{done: 1'b1, is_in: is_in, ep: ep, count: cnt};
        @(posedge i_clk);
        o_pkt <= '{done: 1'b0, is_in: ~is_in, ep: ~ep, count: ~cnt};
        #1;
    endtask : send
    task automatic line(input logic idle, input logic suspend_request_flag);
        @(posedge i_clk);
        o_bus_idle <= idle;
        o_suspended <= suspend_request_flag;
    endtask : line
endmodule : ufb_eng_model

// >>> ufb_top_tb.sv
`timescale 1ns/1ps
module ufb_top_tb;
    import ufb_pkg::*;
    localparam int IDLE_CYC = 20; // short suspend timer keeps the run brief
    logic        i_clk, i_rst_n, i_ce, i_wr, i_rd, i_global_mask, i_blk_release, i_blk_sel;
    logic [3:0]  i_addr;
    logic [7:0]  i_wdata, o_rdata;
    logic [9:0]  o_ep2_addr, exp_addr;
    logic [1:0]  o_block_status_pair;
    logic        o_ep2_nak, o_current_block_index, o_irq_main, o_irq_wake, bus_idle, suspend_request_flag;
    ufb_pkt_type pkt;
    int          bad_count = 0;
    int          n_compared = 0;
    ufb_top #(.SUSPEND_REQUEST_FLAG_IDLE_CYCLES(IDLE_CYC)) u_ufb_top (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pkt(pkt), .i_setup_ovr(1'b0),
        .i_bus_err(1'b0), .i_bus_reset(1'b0), .i_sof(1'b0), .i_bus_idle(bus_idle),
        .i_suspended(suspend_request_flag), .i_blk_release(i_blk_release), .i_blk_sel(i_blk_sel),
        .i_global_mask(i_global_mask), .o_ep2_addr(o_ep2_addr), .o_ep2_nak(o_ep2_nak),
        .o_block_status_pair(o_block_status_pair), .o_current_block_index(o_current_block_index),
        .o_irq_main(o_irq_main), .o_irq_wake(o_irq_wake));
    ufb_eng_model u_ufb_eng_model (.i_clk(i_clk), .o_pkt(pkt), .o_bus_idle(bus_idle), .o_suspended(suspend_request_flag));
    // ==========================================================
    // bus tasks
    task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
        @(posedge i_clk);
        {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk(nm, 10'(o_rdata), 10'(e));
    endtask : rd
    task automatic rel(input logic s);
        @(posedge i_clk);
        {i_blk_release, i_blk_sel} <= {1'b1, s};
        @(posedge i_clk);
        i_blk_release <= 1'b0;
        @(posedge i_clk); // manager leaves wait one cycle after the status update
        #1;
    endtask : rel
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    // clock and watchdog
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    initial begin
        repeat (3000) @(posedge i_clk);
        bad_count++;
        tally_and_finish();
    end
    // ==========================================================
    // tests
    initial begin
        {i_rst_n, i_wr, i_rd, i_global_mask, i_blk_release, i_blk_sel, i_addr, i_wdata} = '0;
        i_ce = 1'b1;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(REG_BUF_CTRL, 8'h00, "buf_rst");
        wr(4'h9, 8'hFF);
        rd(4'h9, 8'h00, "unmapped");
        $display("test reset done");
        wr(REG_CONTROL, 8'h20);
        repeat (2) @(posedge i_clk);
        #1 chk("nak_dl", 10'(o_ep2_nak), 10'h000);
        // two full blocks of download traffic, the second finding no free block
        for (int k = 1; k <= 16; k++) begin
            u_ufb_eng_model.send(1'b0, 2'h2, EP2_MAX_PACKET);
            exp_addr = 10'((k / 8) % 2 * 512 + (k % 8) * 64);
            chk("ep2_addr", o_ep2_addr, exp_addr);
            chk("nak", 10'(o_ep2_nak), 10'(k == 16));
        end
        rd(REG_BUF_CTRL, 8'h06, "buf_full");
        chk("stat_pair", 10'(o_block_status_pair), 10'h003);
        rel(1'b0);
        chk("nak_rel", 10'(o_ep2_nak), 10'h000);
        rd(REG_BUF_CTRL, 8'h04, "buf_rel");
        wr(REG_BUF_CTRL, 8'h01);
        rd(REG_BUF_CTRL, 8'h00, "buf_clr");
        $display("test download done");
        wr(REG_CONTROL, 8'h10);
        repeat (2) @(posedge i_clk);
        #1 chk("nak_ul", 10'(o_ep2_nak), 10'h001);
        rel(1'b0);
        chk("nak_ul_rel", 10'(o_ep2_nak), 10'h000);
        u_ufb_eng_model.send(1'b1, 2'h2, 7'h0A);
        repeat (2) @(posedge i_clk);
        rd(REG_CONTROL, 8'h00, "mode_short");
        rd(REG_EP2_COUNT, 8'h0A, "count_short");
        chk("blk_short", 10'(o_current_block_index), 10'h000);
        $display("test upload done");
        wr(REG_INT_STATUS, 8'h00);
        wr(REG_INT_ENABLE, 8'h80);
        wr(REG_EP2_STATUS, 8'h03);
        u_ufb_eng_model.send(1'b0, 2'h2, EP2_MAX_PACKET);
        chk("irq_ctr", 10'(o_irq_main), 10'h001);
        rd(REG_EP2_STATUS, 8'h02, "ep2_valid");
        i_global_mask <= 1'b1;
        repeat (2) @(posedge i_clk);
        #1 chk("irq_masked", 10'(o_irq_main), 10'h000);
        i_global_mask <= 1'b0;
        $display("test interrupt done");
        wr(REG_INT_STATUS, 8'h00);
        wr(REG_INT_ENABLE, 8'h04);
        u_ufb_eng_model.line(1'b1, 1'b0);
        repeat (IDLE_CYC + 20) @(posedge i_clk);
        rd(REG_INT_STATUS, 8'h08, "suspend_request_flag_flag");
        u_ufb_eng_model.line(1'b1, 1'b1);
        u_ufb_eng_model.line(1'b0, 1'b0);
        repeat (4) @(posedge i_clk);
        #1 chk("irq_wake", 10'(o_irq_wake), 10'h001);
        chk("irq_main_quiet", 10'(o_irq_main), 10'h000);
        i_ce <= 1'b0;
        u_ufb_eng_model.send(1'b0, 2'h1, 7'h08);
        i_ce <= 1'b1;
        rd(REG_INT_STATUS, 8'h0C, "halt_frozen");
        $display("test suspend done");
        tally_and_finish();
    end
endmodule : ufb_top_tb
